//--- intc_slice_pkg.sv
// Package: register map, field layout and reset values for the interrupt flag/priority slice
package intc_slice_pkg;

  // ****************************************
  // Register map (word addresses on the plain port)
  // ****************************************
  localparam logic [3:0]  ADDR_FLAG_STATUS   = 4'h0;  // Second flag status register
  localparam logic [3:0]  ADDR_PRIORITY      = 4'h1;  // Seventeenth priority control register
  localparam logic [3:0]  ADDR_IRQ_STATUS    = 4'h2;  // Sticky event status, write one to clear
  localparam logic [3:0]  ADDR_IRQ_MASK      = 4'h3;  // Event mask, one enables

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          FLAG_SLAVE_BIT     = 0;     // I2C slave event flag
  localparam int          FLAG_MASTER_BIT    = 1;     // I2C master event flag
  localparam int          FLAG_CMP_BIT       = 2;     // Comparator flag
  localparam int          PRI_DMA6_LSB       = 0;     // DMA channel 6 priority field
  localparam int          PRI_DMA7_LSB       = 4;     // DMA channel 7 priority field
  localparam int          PRI_CAN_LSB        = 8;     // CAN transmit priority field

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [2:0]  PRI_RESET          = 3'h4;  // Each field comes up at code 100
  localparam logic [2:0]  PRI_DISABLED       = 3'h0;  // Code that switches a source off
  localparam logic [15:0] PRI_IMPL_MASK      = 16'h0777; // Implemented priority bits
  localparam logic [2:0]  FLAG_RESET         = 3'h0;  // Flags clear at reset
  localparam logic [2:0]  MASK_RESET         = 3'h0;  // All events masked at reset

endpackage : intc_slice_pkg

//--- intc_slice.sv
// Interrupt flag and priority slice: three request flags, three priority fields
`timescale 1ns/1ns
module intc_slice
  import intc_slice_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1                      // Variant carries a CAN controller
) (
  input  wire logic        sys_clk_in,               // System clock, 100 MHz
  input  wire logic        rstn_in,                  // Asynchronous reset, active low
  input  wire logic [3:0]  addr_in,                  // Register word address
  input  wire logic [15:0] wdata_in,                 // Write data
  input  wire logic        wr_in,                    // Write strobe
  input  wire logic        rd_in,                    // Read strobe
  output logic      [15:0] rdata_out,                // Read data, cycle after strobe
  input  wire logic        cmp_req_in,               // Comparator request pulse
  input  wire logic        i2c_master_req_in,        // I2C master event request pulse
  input  wire logic        i2c_slave_req_in,         // I2C slave event request pulse
  output logic      [2:0]  can_transmit_level_out,   // Effective CAN level, 0 = off
  output logic      [2:0]  dma_channel7_level_out,   // Effective DMA7 level
  output logic      [2:0]  dma_channel6_level_out,   // Effective DMA6 level
  output logic      [2:0]  flags_out,                // Current request flags
  output logic             irq_out                   // Level interrupt
);

  // ****************************************
  // Register map in brief
  // ****************************************
  // Word 0: request flags, bits 2:0 {cmp, master, slave}, upper bits read zero
  // Word 1: priority fields at 10:8, 6:4 and 2:0, holes read zero
  // Word 2: sticky event status, write a one to clear a bit
  // Word 3: event mask, a one lets the event reach irq_out
  // Other words: writes dropped, reads return zero
  //
  // The flag register stays writable so software can also set a flag
  // by hand, for example to test a handler without the peripheral.
  // A request and a software clear in one cycle: the request wins,
  // so an event that lands during the clear is never lost.
  // Priority code 000 parks a source; the level outputs show it as 0.
  // Without a CAN controller the CAN field is still stored and read
  // back, but its effective level is forced to 0 so it can never fire.

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]  flags;            // Request flags {cmp, master, slave}
    logic [2:0]  can_transmit_priority;
    logic [2:0]  dma_channel7_done_priority;
    logic [2:0]  dma_channel6_done_priority;
    logic [2:0]  irq_status;       // Sticky events
    logic [2:0]  irq_mask;         // Event enables
    logic [15:0] rdata;            // Read data register
  } state_t;

  state_t st_r;                    // Registered state
  state_t st_nxt;                  // Next state
  logic [2:0] req;                 // Requests this cycle

  // Effective level: zero when disabled, else the code itself
  function automatic logic [2:0] eff_level(input logic [2:0] code, input logic present);
    eff_level = present ? code : PRI_DISABLED;
  endfunction : eff_level

  // Gather the raw request lines at their flag positions
  always_comb begin
    req                  = '0;
    req[FLAG_CMP_BIT]    = cmp_req_in;
    req[FLAG_MASTER_BIT] = i2c_master_req_in;
    req[FLAG_SLAVE_BIT]  = i2c_slave_req_in;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    // Hold everything by default
    st_nxt       = st_r;
    // Read data return to zero outside the answer cycle
    st_nxt.rdata = 16'h0000;
    // Software writes first, so a request in the same cycle wins below
    if (wr_in) begin
      unique case (addr_in)
        ADDR_FLAG_STATUS: begin
          st_nxt.flags = wdata_in[2:0];       // Bits above 2 dropped
        end
        ADDR_PRIORITY: begin
          st_nxt.can_transmit_priority      = wdata_in[PRI_CAN_LSB +: 3];
          st_nxt.dma_channel7_done_priority = wdata_in[PRI_DMA7_LSB +: 3];
          st_nxt.dma_channel6_done_priority = wdata_in[PRI_DMA6_LSB +: 3];
        end
        ADDR_IRQ_STATUS: begin
          // Only the ones written clear; zeros leave bits alone
          st_nxt.irq_status = st_r.irq_status & ~wdata_in[2:0];
        end
        ADDR_IRQ_MASK: begin
          // Mask takes the written pattern whole
          st_nxt.irq_mask = wdata_in[2:0];
        end
        default: begin
          // Unmapped: write ignored
        end
      endcase
    end
    // Set wins over clear for flags and sticky status
    st_nxt.flags      = st_nxt.flags | req;
    st_nxt.irq_status = st_nxt.irq_status | req;
    // Read answers in the next cycle; unused bits read zero
    // Reads see the state before any write of the same cycle
    if (rd_in) begin
      unique case (addr_in)
        ADDR_FLAG_STATUS: st_nxt.rdata = {13'h0000, st_r.flags};
        ADDR_PRIORITY: st_nxt.rdata = PRI_IMPL_MASK & {5'h00, st_r.can_transmit_priority, 1'b0,
                                       st_r.dma_channel7_done_priority, 1'b0,
                                       st_r.dma_channel6_done_priority};
        ADDR_IRQ_STATUS:  st_nxt.rdata = {13'h0000, st_r.irq_status};
        ADDR_IRQ_MASK:    st_nxt.rdata = {13'h0000, st_r.irq_mask};
        default:          st_nxt.rdata = 16'h0000;  // Unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r.flags                      <= FLAG_RESET;
      st_r.can_transmit_priority      <= PRI_RESET;
      st_r.dma_channel7_done_priority <= PRI_RESET;
      st_r.dma_channel6_done_priority <= PRI_RESET;
      st_r.irq_status                 <= FLAG_RESET;
      st_r.irq_mask                   <= MASK_RESET;
      st_r.rdata                      <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_out              = st_r.rdata;
  assign flags_out              = st_r.flags;
  // Missing controller forces the CAN source off whatever software stored
  assign can_transmit_level_out = eff_level(st_r.can_transmit_priority, HAS_CAN);
  assign dma_channel7_level_out = eff_level(st_r.dma_channel7_done_priority, 1'b1);
  assign dma_channel6_level_out = eff_level(st_r.dma_channel6_done_priority, 1'b1);
  // Level output straight from registers, so it cannot glitch
  assign irq_out                = |(st_r.irq_status & st_r.irq_mask);

  // ****************************************
  // Assertions
  // ****************************************
  property p_cmp_flag;
    @(posedge sys_clk_in) disable iff (!rstn_in) cmp_req_in |=> flags_out[FLAG_CMP_BIT];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("Comparator flag not set");

  property p_master_flag;
    @(posedge sys_clk_in) disable iff (!rstn_in) i2c_master_req_in |=> flags_out[FLAG_MASTER_BIT];
  endproperty
  a_master_flag: assert property (p_master_flag) else $error("Master flag not set");

  property p_slave_flag;
    @(posedge sys_clk_in) disable iff (!rstn_in) i2c_slave_req_in |=> flags_out[FLAG_SLAVE_BIT];
  endproperty
  a_slave_flag: assert property (p_slave_flag) else $error("Slave flag not set");

  sequence s_pri_write(logic [2:0] v);
    wr_in && addr_in == ADDR_PRIORITY && wdata_in[PRI_DMA7_LSB +: 3] == v;
  endsequence

  property p_level_seven;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_pri_write(3'h7) |=> dma_channel7_level_out == 3'h7;
  endproperty
  a_level_seven: assert property (p_level_seven) else $error("Code 111 not level 7");

  property p_level_off;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_pri_write(3'h0) |=> dma_channel7_level_out == 3'h0;
  endproperty
  a_level_off: assert property (p_level_off) else $error("Code 000 not disabled");

  property p_can_absent;
    @(posedge sys_clk_in) disable iff (!rstn_in) !HAS_CAN |-> can_transmit_level_out == 3'h0;
  endproperty
  a_can_absent: assert property (p_can_absent) else $error("CAN source active without controller");

  property p_unimpl_zero;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      rd_in && addr_in == ADDR_PRIORITY |=> (rdata_out & ~PRI_IMPL_MASK) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bits read nonzero");

  property p_reset_value;
    @(posedge sys_clk_in) $rose(rstn_in) |-> dma_channel6_level_out == PRI_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Priority reset not 100");

  // ****************************************
  // Helper sequences for the further checks
  // ****************************************
  // Flag register written while no request fires
  sequence s_flag_write;
    wr_in && addr_in == ADDR_FLAG_STATUS && !(|req);
  endsequence

  // Neither software nor a source touches the flags
  sequence s_quiet;
    !wr_in && !(|req);
  endsequence

  // Priority write carrying a given DMA6 code
  sequence s_dma6_write(logic [2:0] v);
    wr_in && addr_in == ADDR_PRIORITY && wdata_in[PRI_DMA6_LSB +: 3] == v;
  endsequence

  // Any priority write
  sequence s_can_write;
    wr_in && addr_in == ADDR_PRIORITY;
  endsequence

  // Lowest live code gives level 1
  property p_level_one;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_pri_write(3'h1) |=> dma_channel7_level_out == 3'h1;
  endproperty
  a_level_one: assert property (p_level_one) else $error("Code 001 not level 1");

  // Top code on the DMA6 field as well
  property p_dma6_seven;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_dma6_write(3'h7) |=> dma_channel6_level_out == 3'h7;
  endproperty
  a_dma6_seven: assert property (p_dma6_seven) else $error("DMA6 code 111 not level 7");

  // Parking code on the DMA6 field
  property p_dma6_off;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_dma6_write(3'h0) |=> dma_channel6_level_out == 3'h0;
  endproperty
  a_dma6_off: assert property (p_dma6_off) else $error("DMA6 code 000 not disabled");

  // CAN level follows its field only where the controller exists
  property p_can_level;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      s_can_write |=> can_transmit_level_out == (HAS_CAN ? $past(wdata_in[10:8]) : PRI_DISABLED);
  endproperty
  a_can_level: assert property (p_can_level) else $error("CAN level wrong after write");

  // Software write lands in the flags; upper bits have no effect
  property p_flag_write;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_flag_write |=> flags_out == $past(wdata_in[2:0]);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("Flag write not taken");

  // Flags hold while nothing touches them
  property p_flag_hold;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_quiet |=> $stable(flags_out);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flags changed on their own");

  // Flag register reads zero above bit 2
  property p_flag_rdata;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      rd_in && addr_in == ADDR_FLAG_STATUS |=> rdata_out[15:3] == 13'h0000;
  endproperty
  a_flag_rdata: assert property (p_flag_rdata) else $error("Flag upper bits read nonzero");

  // Unmapped words read zero
  property p_unmapped_read;
    @(posedge sys_clk_in) disable iff (!rstn_in) rd_in && addr_in > ADDR_IRQ_MASK |=> rdata_out == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped word read nonzero");

  // Read data only stand in the answer cycle
  property p_rdata_idle;
    @(posedge sys_clk_in) disable iff (!rstn_in) !rd_in |=> rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside answer cycle");

  // Unmasked comparator event raises the interrupt next cycle
  property p_irq_raise;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      cmp_req_in && st_r.irq_mask[FLAG_CMP_BIT] && !wr_in |=> irq_out;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("Unmasked event gave no interrupt");

  // Other fields also come up at code 100
  property p_reset_levels;
    @(posedge sys_clk_in) $rose(rstn_in) |->
      dma_channel7_level_out == PRI_RESET && can_transmit_level_out == (HAS_CAN ? PRI_RESET : PRI_DISABLED);
  endproperty
  a_reset_levels: assert property (p_reset_levels) else $error("Field reset not 100");

endmodule : intc_slice

//--- req_source.sv
// Request source model: peripheral event pulses into the slice
`timescale 1ns/1ns
module req_source (
  input  wire logic       sys_clk_in,  // System clock
  input  wire logic       rstn_in,     // Reset, active low
  input  wire logic [2:0] fire_in,     // Bench command {cmp,master,slave}
  output logic      [2:0] req_out      // Request pulses
);
  // Registered, so requests launch just after an edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) req_out <= 3'h0;
    else req_out <= fire_in;
  end
endmodule : req_source

//--- interrupt_flag_priority_slice_tb_top.sv
// Testbench for the interrupt flag and priority slice
`timescale 1ns/1ns
module interrupt_flag_priority_slice_tb_top;
  import intc_slice_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rstn, wr, rd, rd_q, irq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, lfsr, d;
  logic [2:0]  fire, req, can_l, d7_l, d6_l, flg, nocan_l, exp_f;
  logic [15:0] exp_q[$];                       // Expected read data, oldest first
  int          mismatches, cmp_count, cycles;
  wire  [15:0] lv = {5'h0, can_l, 1'b0, d7_l, 1'b0, d6_l}; // Levels in register layout

  req_source u_req_source (.sys_clk_in(clk), .rstn_in(rstn), .fire_in(fire), .req_out(req));
  intc_slice u_intc_slice (.sys_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cmp_req_in(req[2]), .i2c_master_req_in(req[1]),
    .i2c_slave_req_in(req[0]), .can_transmit_level_out(can_l), .dma_channel7_level_out(d7_l),
    .dma_channel6_level_out(d6_l), .flags_out(flg), .irq_out(irq));
  // Variant without CAN shares all inputs
  intc_slice #(.HAS_CAN(1'b0)) u_intc_slice_nocan (.sys_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(), .cmp_req_in(req[2]),
    .i2c_master_req_in(req[1]), .i2c_slave_req_in(req[0]), .can_transmit_level_out(nocan_l),
    .dma_channel7_level_out(), .dma_channel6_level_out(), .flags_out(), .irq_out());

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Shift register keeps random data repeatable
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(logic [3:0] a, logic [15:0] v);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  // Expectation queued; monitor compares in the answer cycle
  task automatic rd_reg(logic [3:0] a, logic [15:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    exp_q.push_back(e);
    @(posedge clk) rd <= 1'b0;
  endtask : rd_reg
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Read data stand only in the cycle after the strobe; also the hang limit
  always @(posedge clk) begin
    if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
    rd_q <= rd;
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rstn, wr, rd, addr, wdata, fire, exp_f} = '0;
    lfsr = 16'h001b;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(ADDR_PRIORITY, 16'h0444);
    #1 chk("levels", 16'h0444, lv);
    $display("test reset values done");
    // Every code, reserved bits filled with random junk
    for (int c = 0; c < 8; c++) begin
      lfsr = lfsr_next(lfsr);
      d = (lfsr & 16'hf888) | (16'(c) * 16'h0111);
      wr_reg(ADDR_PRIORITY, d);
      rd_reg(ADDR_PRIORITY, d & 16'h0777);
      #1 chk("levels", d & 16'h0777, lv);
      chk("nocan level", 16'h0, {13'h0, nocan_l});
    end
    $display("test priority codes done");
    wr_reg(4'h5, lfsr);
    rd_reg(4'h5, 16'h0);
    wr_reg(ADDR_FLAG_STATUS, 16'hfff8);
    rd_reg(ADDR_FLAG_STATUS, 16'h0);
    $display("test reserved places done");
    // Each source in turn; flags accumulate
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) fire <= 3'h1 << i;
      @(posedge clk) fire <= 3'h0;
      repeat (2) @(posedge clk);
      exp_f[i] = 1'b1;
      #1 chk("flags", {13'h0, exp_f}, {13'h0, flg});
    end
    rd_reg(ADDR_FLAG_STATUS, 16'h0007);
    #1 chk("irq masked", 16'h0, {15'h0, irq});
    wr_reg(ADDR_IRQ_MASK, 16'h0004);
    #1 chk("irq unmasked", 16'h1, {15'h0, irq});
    wr_reg(ADDR_IRQ_STATUS, 16'h0004);
    #1 chk("irq cleared", 16'h0, {15'h0, irq});
    wr_reg(ADDR_FLAG_STATUS, 16'h0);
    rd_reg(ADDR_FLAG_STATUS, 16'h0);
    $display("test flags and interrupt done");
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : interrupt_flag_priority_slice_tb_top
